/* verilog/cipd_pkg.sv */
package cipd_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] PWRCTL_IDX = 8'h87;
	localparam logic [7:0] P3MODE2_IDX = 8'hAD;
	localparam logic [7:0] WAKECFG_IDX = 8'hC0;
	localparam logic [7:0] STATUS_IDX = 8'hC1;

	// Field positions in power_control
	localparam int PC_IDLE_BIT = 0;
	localparam int PC_PDOWN_BIT = 1;
	// Field position in port3_mode_select_two
	localparam int P3_PULLUP_BIT = 6;
	// Field positions in the wake configuration register
	localparam int WC_BOD_BIT = 0;
	localparam int WC_WDT_BIT = 4;

	// Reset values and writable masks
	localparam logic [7:0] PWRCTL_RST = 8'h00;
	localparam logic [7:0] PWRCTL_MASK = 8'hDF;
	localparam logic [7:0] P3MODE2_RST = 8'h00;
	localparam logic WC_WDT_RST = 1'b0;
	localparam logic WC_BOD_RST = 1'b0;

	// Synchroniser width: oscillator stable, pin reset, power-on reset
	localparam int SYNC_W = 3;

	// Gray-coded modes along run, idle, power-down, oscillator wait
	typedef enum logic [1:0] {
		CIPD_RUN = 2'b00,
		CIPD_IDLE = 2'b01,
		CIPD_PDOWN = 2'b11,
		CIPD_OSCWAIT = 2'b10
	} cipd_mode_type;

	// Enabled wake-capable interrupt requests
	typedef struct packed {
		logic brownout_detector;
		logic wake_up_timer;
		logic wdt;
		logic pin;
		logic ext1;
		logic ext0;
	} cipd_wake_type;

	// Reset sources that may end a low-power mode
	typedef struct packed {
		logic wdt;
		logic brownout_detector;
	} cipd_reset_type;

	// Whole state of the controller
	typedef struct packed {
		cipd_mode_type mode;
		logic [7:0] pwr;
		logic [7:0] p3mode;
		logic wdtLowPower;
		logic bodEnable;
		logic bodArmed;
		logic wrPend;
		logic [7:0] wrIdx;
		logic [31:0] rdata;
		logic wakeTake;
		logic restart;
		logic [SYNC_W-1:0] sync1;
		logic [SYNC_W-1:0] sync2;
		logic [SYNC_W-1:0] sync3;
		logic [SYNC_W-1:0] filt;
	} cipd_state_type;
endpackage

/* verilog/cipd_power_ctrl.sv */
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
module cipd_power_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Wake and reset sources
	input wire logic anyIrq,
	input wire cipd_pkg::cipd_wake_type wakeReq,
	input wire cipd_pkg::cipd_reset_type resetReq,
	input wire logic pinResetPin,
	input wire logic porResetPin,
	input wire logic oscStablePin,
	input wire logic resetPinDisableConfig,
	// Clock and power controls
	output logic cpuClkEn,
	output logic periphClkEn,
	output logic oscEnable,
	output logic flashStop,
	output logic portHold,
	output logic wdtRunEn,
	output logic wakeTake,
	output logic cpuRestart,
	output logic pullupEnable
);
	cipd_pkg::cipd_state_type r;
	cipd_pkg::cipd_state_type next_r;
	logic oscOk;
	logic hardEnd;
	logic bodOk;
	logic lowPower;
	logic addrOk;
	logic wPwr;
	logic anyWake;
	logic [31:0] rdMux;

	// The agreement filter below is written for exactly three synchronised pins
	if (cipd_pkg::SYNC_W != 3) begin : g_sync_w
		$error("synchroniser width must be three");
	end

	// Filtered pin levels; only filt is ever looked at
	assign oscOk = r.filt[0];
	// Any enabled wake source; anything outside the list is ignored
	assign anyWake = |wakeReq;
	assign lowPower = r.mode != cipd_pkg::CIPD_RUN;
	// Brown-out only ends power-down if detection was on at entry
	assign bodOk = resetReq.brownout_detector & (r.mode == cipd_pkg::CIPD_IDLE | r.bodArmed);
	// Software reset is deliberately absent from this list
	assign hardEnd = r.filt[1] | r.filt[2] | resetReq.wdt | bodOk;
	assign addrOk = haddr[31:10] == 22'h00_0000 && haddr[1:0] == 2'b00;
	assign wPwr = r.wrPend && r.wrIdx == cipd_pkg::PWRCTL_IDX;

	// Read data for the address phase, zero when unmapped
	always_comb begin
		rdMux = 32'h0000_0000;
		if (addrOk) begin
			case (haddr[9:2])
				cipd_pkg::PWRCTL_IDX: rdMux[7:0] = r.pwr;
				cipd_pkg::P3MODE2_IDX: rdMux[7:0] = r.p3mode;
				cipd_pkg::WAKECFG_IDX: begin
					rdMux[cipd_pkg::WC_BOD_BIT] = r.bodEnable;
					rdMux[cipd_pkg::WC_WDT_BIT] = r.wdtLowPower;
				end
				cipd_pkg::STATUS_IDX: rdMux[4:0] = {r.bodArmed, oscOk, lowPower, r.mode};
				default: rdMux = 32'h0000_0000;
			endcase
		end
	end

	// Next state
	always_comb begin
		next_r = r;
		next_r.wakeTake = 1'b0;
		next_r.restart = 1'b0;
		// Three-stage synchroniser, change accepted once stages two and three agree
		next_r.sync1 = {porResetPin, pinResetPin, oscStablePin};
		next_r.sync2 = r.sync1;
		next_r.sync3 = r.sync2;
		next_r.filt = (r.sync2 & r.sync3) | (r.filt & (r.sync2 | r.sync3));
		// Stopped oscillator must prove itself again; a stale stable level
		// from before power-down would otherwise skip the warm-up wait
		if (r.mode == cipd_pkg::CIPD_PDOWN) begin
			next_r.sync1[0] = 1'b0;
			next_r.sync2[0] = 1'b0;
			next_r.sync3[0] = 1'b0;
			next_r.filt[0] = 1'b0;
		end
		// Address phase; read data is registered so it is ready with zero waits
		next_r.wrPend = 1'b0;
		if (hsel && hready && htrans[1]) begin
			next_r.wrPend = hwrite && addrOk;
			next_r.wrIdx = haddr[9:2];
			next_r.rdata = rdMux;
		end
		// Mode sequencing
		unique case (r.mode)
			cipd_pkg::CIPD_RUN: begin
			end
			cipd_pkg::CIPD_IDLE: begin
				if (anyIrq || anyWake) begin
					next_r.pwr[cipd_pkg::PC_IDLE_BIT] = 1'b0;
					next_r.mode = cipd_pkg::CIPD_RUN;
					next_r.wakeTake = 1'b1;
				end
			end
			cipd_pkg::CIPD_PDOWN: begin
				// Oscillator restarted at once; no code runs until it settles
				if (anyWake) begin
					next_r.mode = cipd_pkg::CIPD_OSCWAIT;
				end
			end
			cipd_pkg::CIPD_OSCWAIT: begin
				if (oscOk) begin
					// Both bits cleared so the core never slides into idle
					next_r.pwr[cipd_pkg::PC_PDOWN_BIT] = 1'b0;
					next_r.pwr[cipd_pkg::PC_IDLE_BIT] = 1'b0;
					next_r.mode = cipd_pkg::CIPD_RUN;
					next_r.wakeTake = 1'b1;
				end
			end
		endcase
		// Data phase of a register write
		if (r.wrPend) begin
			case (r.wrIdx)
				cipd_pkg::PWRCTL_IDX: begin
					next_r.pwr = hwdata[7:0] & cipd_pkg::PWRCTL_MASK;
					if (r.mode == cipd_pkg::CIPD_RUN) begin
						// Power-down wins over idle when both are written
						if (hwdata[cipd_pkg::PC_PDOWN_BIT]) begin
							next_r.mode = cipd_pkg::CIPD_PDOWN;
							next_r.bodArmed = r.bodEnable;
						end else if (hwdata[cipd_pkg::PC_IDLE_BIT]) begin
							next_r.mode = cipd_pkg::CIPD_IDLE;
						end
					end
				end
				cipd_pkg::P3MODE2_IDX: next_r.p3mode = hwdata[7:0];
				cipd_pkg::WAKECFG_IDX: begin
					next_r.bodEnable = hwdata[cipd_pkg::WC_BOD_BIT];
					next_r.wdtLowPower = hwdata[cipd_pkg::WC_WDT_BIT];
				end
				default: begin
				end
			endcase
		end
		// Resets other than software reset end any low-power mode, except brown-out in power-down when not armed at entry
		if (lowPower && hardEnd) begin
			next_r.mode = cipd_pkg::CIPD_RUN;
			next_r.pwr[cipd_pkg::PC_PDOWN_BIT] = 1'b0;
			next_r.pwr[cipd_pkg::PC_IDLE_BIT] = 1'b0;
			next_r.wakeTake = 1'b0;
			next_r.restart = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (srst) begin
			r <= '0;
			r.mode <= cipd_pkg::CIPD_RUN;
			r.pwr <= cipd_pkg::PWRCTL_RST;
			r.p3mode <= cipd_pkg::P3MODE2_RST;
			r.wdtLowPower <= cipd_pkg::WC_WDT_RST;
			r.bodEnable <= cipd_pkg::WC_BOD_RST;
		end else begin
			r <= next_r;
		end
	end

	// Bus answers: always ready, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = r.rdata;

	// Clock gates decoded from the registered mode
	assign cpuClkEn = r.mode == cipd_pkg::CIPD_RUN;
	assign periphClkEn = r.mode inside {cipd_pkg::CIPD_RUN, cipd_pkg::CIPD_IDLE};
	assign oscEnable = r.mode != cipd_pkg::CIPD_PDOWN;
	assign flashStop = r.mode inside {cipd_pkg::CIPD_PDOWN, cipd_pkg::CIPD_OSCWAIT};
	// Pins keep their last driven state whenever the core is stopped
	assign portHold = lowPower;
	assign wdtRunEn = cpuClkEn | r.wdtLowPower;
	assign wakeTake = r.wakeTake;
	assign cpuRestart = r.restart;
	// Pull-up bit only acts while the pin-disable setting is clear
	assign pullupEnable = resetPinDisableConfig ? 1'b1 : r.p3mode[cipd_pkg::P3_PULLUP_BIT];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	// Power-down gates the core, peripheral and oscillator clocks
	pd_clocks_off_a: assert property (
		r.mode == cipd_pkg::CIPD_PDOWN |-> !cpuClkEn && !periphClkEn && !oscEnable)
		else $error("clocks running in power-down");

	// Idle write stops the core on the next edge
	idle_entry_a: assert property (
		wPwr && r.mode == cipd_pkg::CIPD_RUN && hwdata[1:0] == 2'b01 && !hardEnd
		|=> !cpuClkEn && periphClkEn && r.mode == cipd_pkg::CIPD_IDLE)
		else $error("idle entry wrong");

	// Both bits written gives power-down
	both_bits_pd_a: assert property (
		wPwr && r.mode == cipd_pkg::CIPD_RUN && hwdata[1:0] == 2'b11 && !hardEnd
		|=> r.mode == cipd_pkg::CIPD_PDOWN)
		else $error("both bits did not enter power-down");

	// Power-down exit clears both bits and takes the interrupt
	pd_exit_clear_a: assert property (
		r.mode == cipd_pkg::CIPD_OSCWAIT && oscOk && !hardEnd && !wPwr
		|=> cpuClkEn && wakeTake && r.pwr[1:0] == 2'b00)
		else $error("power-down exit wrong");

	// Idle ends on an interrupt within one cycle
	idle_wake_a: assert property (
		r.mode == cipd_pkg::CIPD_IDLE && anyIrq && !hardEnd && !wPwr
		|=> cpuClkEn && wakeTake && !r.pwr[cipd_pkg::PC_IDLE_BIT])
		else $error("idle did not wake");

	// Reset event ends low power and restarts the core
	reset_end_a: assert property (
		lowPower && hardEnd |=> cpuClkEn && cpuRestart && !wakeTake)
		else $error("reset did not end low power");

	// No interrupt is taken before the oscillator settles
	osc_wait_a: assert property (
		r.mode == cipd_pkg::CIPD_PDOWN && anyWake && !hardEnd && !wPwr
		|=> r.mode == cipd_pkg::CIPD_OSCWAIT && oscEnable && !cpuClkEn && !wakeTake)
		else $error("oscillator wait skipped");

	// Power-down holds without a listed wake source
	pd_hold_a: assert property (
		r.mode == cipd_pkg::CIPD_PDOWN && !anyWake && !hardEnd && !wPwr
		|=> r.mode == cipd_pkg::CIPD_PDOWN && flashStop && portHold)
		else $error("power-down left without wake source");

	// Watchdog gating in idle
	wdt_idle_a: assert property (
		r.mode == cipd_pkg::CIPD_IDLE |-> wdtRunEn == r.wdtLowPower)
		else $error("watchdog gating wrong in idle");

	// Pull-up selection
	pullup_sel_a: assert property (
		resetPinDisableConfig |-> pullupEnable)
		else $error("pull-up dropped");

	// Flash stopped and pins held throughout power-down
	pd_flash_hold_a: assert property (
		r.mode == cipd_pkg::CIPD_PDOWN |-> flashStop && portHold && !oscEnable)
		else $error("flash or pins not held in power-down");

	// Idle freezes the core and the pins
	idle_freeze_a: assert property (
		r.mode == cipd_pkg::CIPD_IDLE |-> portHold && !cpuClkEn)
		else $error("core not frozen in idle");

	// Peripherals and oscillator keep running in idle
	idle_periph_a: assert property (
		r.mode == cipd_pkg::CIPD_IDLE |-> periphClkEn && oscEnable && !flashStop)
		else $error("peripheral clock stopped in idle");

	// Only a power_control write stops the running core
	run_no_stop_a: assert property (
		r.mode == cipd_pkg::CIPD_RUN && !wPwr |=> cpuClkEn)
		else $error("core stopped without a write");

	// Stable level is forgotten once the oscillator stops
	osc_flush_a: assert property (
		r.mode == cipd_pkg::CIPD_PDOWN |=> !oscOk)
		else $error("stale oscillator stable level");

	// Core stays stopped until the oscillator settles
	osc_hold_a: assert property (
		r.mode == cipd_pkg::CIPD_OSCWAIT && !oscOk && !hardEnd
		|=> r.mode == cipd_pkg::CIPD_OSCWAIT && !cpuClkEn && !wakeTake)
		else $error("oscillator wait left early");

	// Brown-out not armed at entry leaves power-down alone
	bod_unarmed_a: assert property (
		r.mode == cipd_pkg::CIPD_PDOWN && resetReq.brownout_detector && !r.bodArmed
		&& !r.filt[1] && !r.filt[2] && !resetReq.wdt && !anyWake
		|=> r.mode == cipd_pkg::CIPD_PDOWN && !cpuRestart)
		else $error("unarmed brown-out ended power-down");

	// Restart leaves the core running with both bits clear
	restart_state_a: assert property (
		cpuRestart |-> cpuClkEn && r.pwr[1:0] == 2'h0)
		else $error("restart with mode bits set");

	// Pull-up follows its bit while the pin-disable setting is clear
	pullup_follow_a: assert property (
		!resetPinDisableConfig |-> pullupEnable == r.p3mode[cipd_pkg::P3_PULLUP_BIT])
		else $error("pull-up does not follow its bit");

	// Watchdog always runs while the core runs
	wdt_run_a: assert property (
		cpuClkEn |-> wdtRunEn)
		else $error("watchdog stopped while running");

	// No interrupt is taken from power-down without a listed source
	pd_no_take_a: assert property (
		r.mode == cipd_pkg::CIPD_PDOWN && !anyWake && !hardEnd
		|=> !wakeTake && !cpuClkEn)
		else $error("interrupt taken from power-down");

	// Entry copies the brown-out enable into the armed flag
	pd_entry_bod_a: assert property (
		wPwr && r.mode == cipd_pkg::CIPD_RUN && hwdata[cipd_pkg::PC_PDOWN_BIT] && !hardEnd
		|=> r.mode == cipd_pkg::CIPD_PDOWN && r.bodArmed == $past(r.bodEnable))
		else $error("brown-out arm not captured");

	idle_wake_c: cover property (r.mode == cipd_pkg::CIPD_IDLE ##1 wakeTake);
	pd_wake_c: cover property (r.mode == cipd_pkg::CIPD_OSCWAIT ##1 wakeTake);
	reset_exit_c: cover property (flashStop ##1 cpuRestart);
	pd_entry_c: cover property (wPwr && r.mode == cipd_pkg::CIPD_RUN ##1 flashStop);
	bod_end_c: cover property (r.mode == cipd_pkg::CIPD_PDOWN && resetReq.brownout_detector ##1 cpuRestart);
endmodule

/* sim/cipd_osc_model.sv */
`timescale 1ns/1ps
module cipd_osc_model #(
	parameter int STARTUP = 5
) (
	// Clock
	input wire logic clk,
	// Oscillator control and status
	input wire logic oscEnable,
	output logic oscStablePin
);
	int count = 0;
	initial oscStablePin = 1'b0;
	// Stable only after a full warm-up; drops at once when stopped
	always @(posedge clk) begin
		if (!oscEnable) begin
			count <= 0;
			oscStablePin <= 1'b0;
		end else begin
			count <= (count < STARTUP) ? count + 1 : count;
			oscStablePin <= (count >= STARTUP);
		end
	end
endmodule

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
	localparam logic [31:0] A_PC = 32'h0000_021C;
	localparam logic [31:0] A_P3 = 32'h0000_02B4;
	localparam logic [31:0] A_WC = 32'h0000_0300;
	localparam logic [31:0] A_UN = 32'h0000_0400;
	localparam logic [31:0] A_ST = 32'h0000_0304;
	logic clk, srst, hsel, hwrite, hready, hreadyout, hresp, anyIrq;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	cipd_pkg::cipd_wake_type wakeReq;
	cipd_pkg::cipd_reset_type resetReq;
	logic pinResetPin, porResetPin, oscStablePin, rpdCfg;
	logic cpuClkEn, periphClkEn, oscEnable, flashStop, portHold, wdtRunEn;
	logic wakeTake, cpuRestart, pullupEnable;
	logic [31:0] rowAddr [5] = '{A_P3, A_PC, A_WC, A_UN, A_PC};
	logic [31:0] rowData [5] = '{32'h0000_0040, 32'h0000_00FC, 32'h0000_0011, 32'h0000_00FF,
		32'h0000_0000};
	logic [31:0] rowExp [5] = '{32'h0000_0040, 32'h0000_00DC, 32'h0000_0011, 32'h0000_0000,
		32'h0000_0000};
	int nErrors = 0, nTests = 0, nWake = 0, nRestart = 0;
	// Single slave on the bus
	assign hready = hreadyout;
	cipd_power_ctrl cipd_power_ctrl_inst (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .anyIrq(anyIrq),
		.wakeReq(wakeReq), .resetReq(resetReq), .pinResetPin(pinResetPin),
		.porResetPin(porResetPin), .oscStablePin(oscStablePin),
		.resetPinDisableConfig(rpdCfg), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
		.oscEnable(oscEnable), .flashStop(flashStop), .portHold(portHold),
		.wdtRunEn(wdtRunEn), .wakeTake(wakeTake), .cpuRestart(cpuRestart),
		.pullupEnable(pullupEnable));
	cipd_osc_model cipd_osc_model_inst (.clk(clk), .oscEnable(oscEnable),
		.oscStablePin(oscStablePin));
	// Count one-cycle pulses so waits need not catch them live
	always @(posedge clk) begin
		if (wakeTake === 1'b1) nWake <= nWake + 1;
		if (cpuRestart === 1'b1) nRestart <= nRestart + 1;
	end
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task endSim;
		if (nErrors == 0 && nTests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			nErrors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Bounded wait for the slave; a hang ends the run
	task waitReady;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			if (hready === 1'b1) return;
		end
		nErrors++;
		endSim;
	endtask
	task busOp(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge clk);
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		waitReady;
		htrans <= 2'b00;
		hwdata <= wd;
		waitReady;
		rd = hrdata;
	endtask
	task waitRun;
		for (int i = 0; i < 40; i++) begin
			@(negedge clk);
			if (cpuClkEn === 1'b1) return;
		end
		nErrors++;
		endSim;
	endtask
	// Main sequence
	initial begin
		srst = 1'b1;
		{hsel, hwrite, anyIrq, pinResetPin, porResetPin, rpdCfg} = '0;
		{htrans, haddr, hwdata, wakeReq, resetReq} = '0;
		hsize = 3'b010;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		hsel <= 1'b1;
		busOp(0, A_PC, 0);
		check(rd, 0);
		busOp(0, A_P3, 0);
		check(rd, 0);
		for (int r = 0; r < 5; r++) begin
			busOp(1, rowAddr[r], rowData[r]);
			busOp(0, rowAddr[r], 0);
			check(rd, rowExp[r]);
			check(hresp, 1'b0);
		end
		check(pullupEnable, 1);
		busOp(1, A_P3, 0);
		@(negedge clk);
		check(pullupEnable, 0);
		@(posedge clk);
		rpdCfg <= 1'b1;
		@(negedge clk);
		check(pullupEnable, 1);
		// Idle entry and interrupt wake
		busOp(1, A_PC, 1);
		@(negedge clk);
		check({cpuClkEn, periphClkEn, portHold, wdtRunEn}, 4'b0111);
		busOp(0, A_ST, 0);
		check(rd, 32'h0000_000D);
		@(posedge clk);
		anyIrq <= 1'b1;
		waitRun;
		// Pulse counter moves one edge after the pulse
		@(posedge clk);
		anyIrq <= 1'b0;
		@(negedge clk);
		check(nWake, 1);
		busOp(0, A_PC, 0);
		check(rd, 0);
		// Power-down with both bits and the watchdog stopped
		busOp(1, A_WC, 1);
		busOp(1, A_PC, 3);
		@(negedge clk);
		check({cpuClkEn, periphClkEn, oscEnable, flashStop, portHold, wdtRunEn}, 6'b000110);
		busOp(0, A_ST, 0);
		check(rd, 32'h0000_0017);
		@(posedge clk);
		anyIrq <= 1'b1;
		repeat (3) @(posedge clk);
		anyIrq <= 1'b0;
		@(negedge clk);
		check(periphClkEn, 0);
		@(posedge clk);
		wakeReq <= 6'h01;
		repeat (2) @(negedge clk);
		check({oscEnable, cpuClkEn}, 2'b10);
		waitRun;
		@(posedge clk);
		wakeReq <= '0;
		@(negedge clk);
		check(nWake, 2);
		busOp(0, A_PC, 0);
		check(rd, 0);
		// Reset sources ending idle or power-down
		for (int k = 0; k < 4; k++) begin
			busOp(1, A_PC, (k == 0) ? 1 : 2);
			@(posedge clk);
			resetReq <= (k == 0) ? 2'h2 : (k == 1) ? 2'h1 : 2'h0;
			pinResetPin <= (k == 2);
			porResetPin <= (k == 3);
			waitRun;
			@(posedge clk);
			{resetReq, pinResetPin, porResetPin} <= '0;
			// Let the pin filters drain before the next entry
			repeat (6) @(posedge clk);
			check(nRestart, k + 1);
			check(nWake, 2);
		end
		// Brown-out not armed at entry must not end power-down
		busOp(1, A_WC, 0);
		busOp(1, A_PC, 2);
		@(posedge clk);
		resetReq <= 2'h1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		check(cpuClkEn, 0);
		check(nRestart, 4);
		@(posedge clk);
		resetReq <= '0;
		wakeReq <= 6'h02;
		waitRun;
		@(posedge clk);
		wakeReq <= '0;
		@(negedge clk);
		check(nWake, 3);
		// Bus reset in mid-run, from power-down
		busOp(1, A_WC, 32'h0000_0011);
		busOp(1, A_PC, 2);
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		check({cpuClkEn, periphClkEn, oscEnable, flashStop, portHold, wakeTake}, 6'b111000);
		busOp(0, A_PC, 0);
		check(rd, 0);
		busOp(0, A_WC, 0);
		check(rd, 0);
		check(nRestart, 4);
		endSim;
	end
endmodule
